// [common/dhic_defs.svh]
// Constants for the display host interface control block
`ifndef DHIC_DEFS_SVH
`define DHIC_DEFS_SVH
`define DHIC_CLK_MHZ 10
`define DHIC_INIT_NS 2000
`define DHIC_INIT_CYC ((`DHIC_INIT_NS * `DHIC_CLK_MHZ + 999) / 1000)
`define DHIC_STRAP_SPI 3'h0
`define DHIC_STRAP_I2C 3'h2
`define DHIC_STRAP_PAR_SEP 3'h4
`define DHIC_STRAP_PAR_E 3'h6
`define DHIC_SCLK_BIT 0
`define DHIC_SER_DATA_BIT 1
`define DHIC_SDA_OUT_BIT 2
// Upper slave address bits, value arbitrary
`define DHIC_I2C_ADDR_HI 6'h2A
`define DHIC_I2C_DC_BIT 6
`define DHIC_FIFO_DEPTH 4
`define DHIC_FIFO_W 9
`endif

// [common/dhic_fifo_if.sv]
// Valid/ready carrier between the block and its FIFO
`timescale 1ns/1ps
`default_nettype none
interface dhic_fifo_if #(parameter int W = 9);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [common/dhic_pkg.sv]
// Types for the display host interface control block
package dhic_pkg;
   typedef enum logic [1:0] {
      DHIC_PAR_E = 2'h0,
      DHIC_PAR_SEP = 2'h1,
      DHIC_SPI = 2'h2,
      DHIC_I2C = 2'h3
   } dhic_mode_t;
   typedef enum logic [1:0] {
      DHIC_I_IDLE = 2'h0,
      DHIC_I_ADDR = 2'h1,
      DHIC_I_CTRL = 2'h2,
      DHIC_I_DATA = 2'h3
   } dhic_i2c_t;
endpackage

// [rtl/dhic_fifo.sv]
// Small FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dhic_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   dhic_fifo_if.snk wr,
   dhic_fifo_if.src rd
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0] mem_q [DEPTH];
   logic [W-1:0] mem_d [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   always_comb begin
      wr.ready = (cnt_q != (AW+1)'(DEPTH));
      rd.valid = (cnt_q != '0);
      rd.data = mem_q[rp_q];
      push = wr.valid && wr.ready;
      pop = rd.valid && rd.ready;
      mem_d = mem_q;
      wp_d = wp_q;
      rp_d = rp_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wp_q] = wr.data;
         wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
         rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else if (clk_en) begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
         mem_q <= mem_d;
      end
   end
endmodule
`default_nettype wire

// [rtl/dhic_top.sv]
// Host interface control: pin decode, serial and I2C capture, byte stream
`timescale 1ns/1ps
`default_nettype none
`include "dhic_defs.svh"
module dhic_top import dhic_pkg::*; #(
   parameter int DEPTH = `DHIC_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic power_init_low,
   input wire logic device_select_b,
   input wire logic data_cmd_sel,
   input wire logic en_rd_strobe,
   input wire logic rw_wr_strobe,
   input wire logic protocol_strap_0,
   input wire logic protocol_strap_1,
   input wire logic protocol_strap_2,
   input wire logic [7:0] host_data_bus_in,
   output logic [7:0] host_data_bus_out,
   output logic [7:0] host_data_bus_oe_b,
   input wire logic [7:0] read_byte,
   output logic read_pulse,
   output logic read_is_data,
   output logic out_valid,
   output logic [7:0] out_byte,
   output logic out_is_data,
   input wire logic out_ready,
   output logic in_stall,
   output logic overrun,
   input wire logic overrun_clr,
   output logic init_busy,
   output logic [1:0] mode
);
   localparam int P_RST = 15;
   localparam int P_CS = 14;
   localparam int P_DC = 13;
   localparam int P_E = 12;
   localparam int P_RW = 11;
   localparam int IW = 8;
   localparam int FW = `DHIC_FIFO_W;

   function automatic logic up(input logic now, input logic was);
      return now & ~was;
   endfunction

   function automatic dhic_mode_t strap_mode(input logic [2:0] s);
      case (s)
         `DHIC_STRAP_I2C: return DHIC_I2C;
         `DHIC_STRAP_PAR_SEP: return DHIC_PAR_SEP;
         `DHIC_STRAP_PAR_E: return DHIC_PAR_E;
         default: return DHIC_SPI;
      endcase
   endfunction

   // Every pin passes two flops; pv_q only ever looks at stage two
   logic [15:0] pin_w, s1_q, s2_q, pv_q;
   assign pin_w = {power_init_low, device_select_b, data_cmd_sel, en_rd_strobe,
                   rw_wr_strobe, protocol_strap_2, protocol_strap_1,
                   protocol_strap_0, host_data_bus_in};

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s1_q <= 16'hFFFF;
         s2_q <= 16'hFFFF;
         pv_q <= 16'hFFFF;
      end else if (clk_en) begin
         s1_q <= pin_w;
         s2_q <= s1_q;
         pv_q <= s2_q;
      end
   end

   logic [IW-1:0] init_q, init_d;
   dhic_mode_t mode_q, mode_d;
   logic live, cs_on, dc, scl, sda;
   logic [7:0] bus;

   always_comb begin
      init_d = init_q;
      mode_d = mode_q;
      if (!s2_q[P_RST]) begin
         init_d = IW'(`DHIC_INIT_CYC);
         mode_d = strap_mode(s2_q[10:8]);
      end else if (init_q != '0) begin
         init_d = init_q - 1'b1;
      end
      cs_on = !s2_q[P_CS];
      live = s2_q[P_RST] && (init_q == '0) && cs_on;
      dc = s2_q[P_DC];
      bus = s2_q[7:0];
      scl = s2_q[`DHIC_SCLK_BIT];
      sda = s2_q[`DHIC_SER_DATA_BIT];
   end

   // Parallel strobes
   logic rd_act, rd_was_q, wr_end;
   logic [7:0] hd_out_d, hd_oe_b_d;
   logic rdp_d, rdd_d, rdd_q;
   logic ack_q, ack_d;

   always_comb begin
      rd_act = 1'b0;
      wr_end = 1'b0;
      if (mode_q == DHIC_PAR_E) begin
         rd_act = live && s2_q[P_E] && s2_q[P_RW];
         wr_end = live && !s2_q[P_E] && pv_q[P_E] && !s2_q[P_RW];
      end else if (mode_q == DHIC_PAR_SEP) begin
         rd_act = live && !s2_q[P_E];
         wr_end = live && up(s2_q[P_RW], pv_q[P_RW]);
      end
      rdp_d = rd_act && !rd_was_q;
      rdd_d = rdp_d ? dc : rdd_q;
      hd_out_d = 8'hFF;
      hd_oe_b_d = 8'hFF;
      if (rd_act) begin
         hd_out_d = read_byte;
         hd_oe_b_d = 8'h00;
      end else if (ack_q) begin
         hd_out_d[`DHIC_SDA_OUT_BIT] = 1'b0;
         hd_oe_b_d[`DHIC_SDA_OUT_BIT] = 1'b0;
      end
   end

   // Serial shift
   logic [7:0] spi_sh_q, spi_sh_d;
   logic [2:0] spi_cnt_q, spi_cnt_d;
   logic spi_push;

   always_comb begin
      spi_sh_d = spi_sh_q;
      spi_cnt_d = spi_cnt_q;
      spi_push = 1'b0;
      if (mode_q != DHIC_SPI || !live) begin
         spi_cnt_d = 3'h0;
      end else if (up(scl, pv_q[`DHIC_SCLK_BIT])) begin
         spi_sh_d = {spi_sh_q[6:0], sda};
         spi_cnt_d = spi_cnt_q + 3'h1;
         spi_push = (spi_cnt_q == 3'h7);
      end
   end

   // I2C slave, write direction only
   dhic_i2c_t ist_q, ist_d;
   logic [7:0] ish_q, ish_d;
   logic [3:0] icnt_q, icnt_d;
   logic idc_q, idc_d, i2c_push;
   logic scl_r, scl_f, sda_r, sda_f, a_hit;

   always_comb begin
      ist_d = ist_q;
      ish_d = ish_q;
      icnt_d = icnt_q;
      idc_d = idc_q;
      ack_d = ack_q;
      i2c_push = 1'b0;
      scl_r = up(scl, pv_q[`DHIC_SCLK_BIT]);
      scl_f = up(pv_q[`DHIC_SCLK_BIT], scl);
      sda_r = up(sda, pv_q[`DHIC_SER_DATA_BIT]);
      sda_f = up(pv_q[`DHIC_SER_DATA_BIT], sda);
      a_hit = (ish_q[7:1] == {`DHIC_I2C_ADDR_HI, dc}) && !ish_q[0];
      if (mode_q != DHIC_I2C || !live) begin
         ist_d = DHIC_I_IDLE;
         ack_d = 1'b0;
      end else if (scl && pv_q[`DHIC_SCLK_BIT] && sda_f) begin
         ist_d = DHIC_I_ADDR;
         icnt_d = 4'h0;
         ack_d = 1'b0;
      end else if (scl && pv_q[`DHIC_SCLK_BIT] && sda_r) begin
         ist_d = DHIC_I_IDLE;
         ack_d = 1'b0;
      end else if (ist_q != DHIC_I_IDLE) begin
         if (scl_r && !ack_q) begin
            ish_d = {ish_q[6:0], sda};
            icnt_d = icnt_q + 4'h1;
         end else if (scl_f && ack_q) begin
            ack_d = 1'b0;
            icnt_d = 4'h0;
            if (ist_q == DHIC_I_ADDR) begin
               ist_d = DHIC_I_CTRL;
            end else begin
               ist_d = DHIC_I_DATA;
            end
         end else if (scl_f && icnt_q == 4'h8) begin
            unique case (ist_q)
               DHIC_I_ADDR: begin
                  ack_d = a_hit;
                  if (!a_hit) begin
                     ist_d = DHIC_I_IDLE;
                  end
               end
               DHIC_I_CTRL: begin
                  ack_d = 1'b1;
                  idc_d = ish_q[`DHIC_I2C_DC_BIT];
               end
               DHIC_I_DATA: begin
                  ack_d = 1'b1;
                  i2c_push = 1'b1;
               end
               DHIC_I_IDLE: begin
                  ack_d = 1'b0;
               end
            endcase
         end
      end
   end

   // One byte waits here when the FIFO pushes back
   dhic_fifo_if #(.W(FW)) f_in ();
   dhic_fifo_if #(.W(FW)) f_out ();
   logic push;
   logic [FW-1:0] push_w, pend_q, pend_d;
   logic pend_v_q, pend_v_d, ovr_q, ovr_d;
   logic ov_q, ov_d, od_q, od_d;
   logic [7:0] ob_q, ob_d;

   always_comb begin
      push = 1'b0;
      push_w = {dc, bus};
      unique case (mode_q)
         DHIC_PAR_E, DHIC_PAR_SEP: begin
            push = wr_end;
            push_w = {dc, bus};
         end
         DHIC_SPI: begin
            push = spi_push;
            push_w = {dc, spi_sh_d};
         end
         DHIC_I2C: begin
            push = i2c_push;
            push_w = {idc_q, ish_q};
         end
      endcase
      pend_d = pend_q;
      pend_v_d = pend_v_q && !f_in.ready;
      ovr_d = ovr_q && !overrun_clr;
      if (push) begin
         pend_d = push_w;
         pend_v_d = 1'b1;
         if (pend_v_q && !f_in.ready) begin
            ovr_d = 1'b1;
         end
      end
      f_out.ready = !ov_q || out_ready;
      ov_d = ov_q && !out_ready;
      ob_d = ob_q;
      od_d = od_q;
      if (f_out.ready && f_out.valid) begin
         ov_d = 1'b1;
         {od_d, ob_d} = f_out.data;
      end
   end

   assign f_in.valid = pend_v_q;
   assign f_in.data = pend_q;

   dhic_fifo #(.W(FW), .DEPTH(DEPTH)) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .wr(f_in),
      .rd(f_out)
   );

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         init_q <= IW'(`DHIC_INIT_CYC);
         mode_q <= DHIC_PAR_E;
         rd_was_q <= 1'b0;
         rdd_q <= 1'b0;
         ack_q <= 1'b0;
         spi_sh_q <= 8'h00;
         spi_cnt_q <= 3'h0;
         ist_q <= DHIC_I_IDLE;
         ish_q <= 8'h00;
         icnt_q <= 4'h0;
         idc_q <= 1'b0;
         pend_q <= '0;
         pend_v_q <= 1'b0;
         ovr_q <= 1'b0;
         ov_q <= 1'b0;
         ob_q <= 8'h00;
         od_q <= 1'b0;
         host_data_bus_out <= 8'hFF;
         host_data_bus_oe_b <= 8'hFF;
         read_pulse <= 1'b0;
         init_busy <= 1'b1;
      end else if (clk_en) begin
         init_q <= init_d;
         mode_q <= mode_d;
         rd_was_q <= rd_act;
         rdd_q <= rdd_d;
         ack_q <= ack_d;
         spi_sh_q <= spi_sh_d;
         spi_cnt_q <= spi_cnt_d;
         ist_q <= ist_d;
         ish_q <= ish_d;
         icnt_q <= icnt_d;
         idc_q <= idc_d;
         pend_q <= pend_d;
         pend_v_q <= pend_v_d;
         ovr_q <= ovr_d;
         ov_q <= ov_d;
         ob_q <= ob_d;
         od_q <= od_d;
         host_data_bus_out <= hd_out_d;
         host_data_bus_oe_b <= hd_oe_b_d;
         read_pulse <= rdp_d;
         init_busy <= (init_d != '0);
      end
   end

   always_comb begin
      read_is_data = rdd_q;
      out_valid = ov_q;
      out_byte = ob_q;
      out_is_data = od_q;
      in_stall = pend_v_q;
      overrun = ovr_q;
      mode = mode_q;
   end
endmodule
`default_nettype wire

// [testbench/dhic_chk_checker.sv]
// Concurrent checks on the host interface control ports
`timescale 1ns/1ps
`default_nettype none
module dhic_chk (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic power_init_low,
   input wire logic device_select_b,
   input wire logic en_rd_strobe,
   input wire logic rw_wr_strobe,
   input wire logic overrun_clr,
   input wire logic out_ready,
   input wire logic [1:0] mode,
   input wire logic init_busy,
   input wire logic read_pulse,
   input wire logic [7:0] host_data_bus_oe_b,
   input wire logic out_valid,
   input wire logic [7:0] out_byte,
   input wire logic out_is_data,
   input wire logic overrun
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Pins pass a two-flop sync, so causes hold a few cycles before effects
   sequence s_sep_rd;
      mode == 2'h1 && !init_busy && $fell(en_rd_strobe) && !device_select_b
      ##1 (!device_select_b && !en_rd_strobe) [*3];
   endsequence
   sequence s_e_rd;
      mode == 2'h0 && !init_busy && $rose(en_rd_strobe) && rw_wr_strobe && !device_select_b
      ##1 (!device_select_b && en_rd_strobe && rw_wr_strobe) [*3];
   endsequence
   sequence s_sep_wr;
      mode == 2'h1 && !init_busy && $rose(rw_wr_strobe) && !device_select_b
      ##1 !device_select_b [*3];
   endsequence
   a_init_hold: assert property (!power_init_low [*5] |-> init_busy)
      else $error("init not busy while power pin low");
   a_init_no_drive: assert property (init_busy |-> host_data_bus_oe_b == 8'hFF)
      else $error("bus driven during init");
   a_desel_no_read: assert property (device_select_b [*5] |-> !read_pulse)
      else $error("read while deselected");
   a_sep_read: assert property (s_sep_rd |-> ##[0:2] read_pulse)
      else $error("separate strobe read not started");
   a_e_read: assert property (s_e_rd |-> ##[0:2] read_pulse)
      else $error("enable strobe read not started");
   a_sep_write: assert property (s_sep_wr |-> ##[1:6] out_valid)
      else $error("separate strobe write not taken");
   a_read_drive: assert property (read_pulse |-> host_data_bus_oe_b == 8'h00)
      else $error("read without bus drive");
   a_pulse_single: assert property (read_pulse |=> !read_pulse)
      else $error("read pulse longer than one cycle");
   a_valid_holds: assert property (out_valid && !out_ready |=>
      out_valid && $stable(out_byte) && $stable(out_is_data))
      else $error("output byte dropped before taken");
   a_overrun_sticky: assert property (overrun && !overrun_clr |=> overrun)
      else $error("overrun cleared by itself");
endmodule
`default_nettype wire

// [testbench/dhic_host.sv]
// Host microcontroller model driving the parallel and serial pins
`timescale 1ns/1ps
`default_nettype none
module dhic_host (
   input wire logic clk,
   input wire logic ack_b,
   output logic cs_b,
   output logic dc,
   output logic en,
   output logic rw,
   output logic [7:0] pins
);
   logic drv;
   logic [7:0] d;
   // Released bus floats: show the inverse so a stale value never matches
   assign pins = drv ? d : ~d;
   initial begin
      cs_b = 1'b1;
      dc = 1'b0;
      en = 1'b1;
      rw = 1'b1;
      drv = 1'b0;
      d = 8'h00;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // e enable-strobe mode, r read, s select level, c data/command
   task automatic acc(input logic e, input logic r, input logic s, input logic c,
         input logic [7:0] b);
      step(1);
      cs_b = s;
      dc = c;
      d = b;
      drv = !r;
      rw = e ? r : 1'b1;
      step(1);
      if (e) en = 1'b1;
      else if (r) en = 1'b0;
      else rw = 1'b0;
      step(4);
      en = !e;
      if (!e) rw = 1'b1;
      // Data and select held past the strobe edge for the sync delay
      step(4);
      cs_b = 1'b1;
      drv = 1'b0;
   endtask
   task automatic spi(input logic c, input logic [7:0] b);
      step(1);
      cs_b = 1'b0;
      dc = c;
      drv = 1'b1;
      d = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         d[1] = b[i];
         step(3);
         d[0] = 1'b1;
         step(3);
         d[0] = 1'b0;
      end
      step(3);
      cs_b = 1'b1;
      drv = 1'b0;
   endtask
   // Strobe idle level differs between the two parallel modes
   task automatic idle(input logic e);
      en = !e;
   endtask
   // I2C write frame: start, three bytes with ack clocks, stop; counts acks
   task automatic i2c(input logic sa, input logic [7:0] a, input logic [7:0] c,
         input logic [7:0] b, output int acks);
      logic [23:0] f;
      f = {a, c, b};
      acks = 0;
      step(1);
      cs_b = 1'b0;
      dc = sa;
      drv = 1'b1;
      d = 8'h03;
      step(4);
      d[1] = 1'b0;
      step(4);
      d[0] = 1'b0;
      for (int j = 23; j >= 0; j--) begin
         step(2);
         d[1] = f[j];
         step(2);
         d[0] = 1'b1;
         step(4);
         d[0] = 1'b0;
         if (j % 8 == 0) begin
            // Ninth clock: SDA at its pull-up level, ack seen on bit 2
            step(2);
            d[1] = 1'b1;
            step(2);
            d[0] = 1'b1;
            step(3);
            if (!ack_b) acks++;
            step(1);
            d[0] = 1'b0;
         end
      end
      step(2);
      d[1] = 1'b0;
      step(2);
      d[0] = 1'b1;
      step(4);
      d[1] = 1'b1;
      step(4);
      cs_b = 1'b1;
      drv = 1'b0;
   endtask
endmodule
`default_nettype wire

// [testbench/tb_display_host_interface_control.sv]
// Testbench for the display host interface control block
`timescale 1ns/1ps
`default_nettype none
`include "dhic_defs.svh"
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin \
   bad_count++; $display("mismatch %s exp %h seen %h", n, e, s); end end
module tb_display_host_interface_control import dhic_pkg::*;;
   logic clk;
   logic rst_b;
   logic pil;
   logic ov_clr;
   logic out_ready;
   logic [2:0] strap;
   logic [7:0] rd_byte;
   logic ce;
   wire logic cs_b, dc, en, rw, read_pulse, read_is_data, out_valid;
   wire logic out_is_data, in_stall, overrun, init_busy;
   wire logic [7:0] hpins, bus_in, bus_out, oe_b, out_byte;
   wire logic [1:0] mode;
   int bad_count;
   int samples_checked;
   assign bus_in = (bus_out & ~oe_b) | (hpins & oe_b);
   dhic_host host (.clk(clk), .ack_b(oe_b[2]), .cs_b(cs_b), .dc(dc), .en(en), .rw(rw),
      .pins(hpins));
   dhic_top #(.DEPTH(4)) DUT (.clk(clk), .rst_b(rst_b), .clk_en(ce),
      .power_init_low(pil), .device_select_b(cs_b), .data_cmd_sel(dc),
      .en_rd_strobe(en), .rw_wr_strobe(rw), .protocol_strap_0(strap[0]),
      .protocol_strap_1(strap[1]), .protocol_strap_2(strap[2]),
      .host_data_bus_in(bus_in), .host_data_bus_out(bus_out), .host_data_bus_oe_b(oe_b),
      .read_byte(rd_byte), .read_pulse(read_pulse), .read_is_data(read_is_data),
      .out_valid(out_valid), .out_byte(out_byte), .out_is_data(out_is_data),
      .out_ready(out_ready), .in_stall(in_stall), .overrun(overrun),
      .overrun_clr(ov_clr), .init_busy(init_busy), .mode(mode));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic init(input logic [2:0] s, input logic [1:0] m);
      int n;
      @(posedge clk) #1;
      strap = s;
      pil = 1'b0;
      host.idle(m == DHIC_PAR_E);
      repeat (8) @(negedge clk);
      `CHK("init_busy", 1'b1, init_busy)
      @(posedge clk) #1;
      pil = 1'b1;
      // Frozen clock enable must stop the init count
      ce = 1'b0;
      repeat (30) @(negedge clk);
      `CHK("init_busy", 1'b1, init_busy)
      @(posedge clk) #1;
      ce = 1'b1;
      for (n = 0; n < 60 && init_busy !== 1'b0; n++) @(negedge clk);
      `CHK("init_busy", 1'b0, init_busy)
      `CHK("mode", m, mode)
      $display("init test %0h done", s);
   endtask
   task automatic get(input logic [7:0] b, input logic c);
      int n;
      for (n = 0; n < 80 && out_valid !== 1'b1; n++) @(negedge clk);
      `CHK("out_valid", 1'b1, out_valid)
      `CHK("out_byte", b, out_byte)
      `CHK("out_is_data", c, out_is_data)
      @(negedge clk);
   endtask
   task automatic rd(input logic e, input logic c);
      int n;
      @(posedge clk) #1;
      rd_byte = 8'h96 ^ {7'h00, c};
      fork
         host.acc(e, 1'b1, 1'b0, c, 8'h00);
         begin
            for (n = 0; n < 20 && read_pulse !== 1'b1; n++) @(negedge clk);
            `CHK("read_pulse", 1'b1, read_pulse)
            `CHK("read_is_data", c, read_is_data)
            `CHK("oe_b", 8'h00, oe_b)
            `CHK("bus_out", rd_byte, bus_out)
         end
      join
      $display("read test done");
   endtask
   task automatic t_fill;
      out_ready = 1'b0;
      for (int i = 0; i < 7; i++) host.acc(1'b0, 1'b0, 1'b0, 1'b1, 8'h10 + i[7:0]);
      repeat (6) @(negedge clk);
      `CHK("overrun", 1'b1, overrun)
      `CHK("in_stall", 1'b1, in_stall)
      @(posedge clk) #1;
      out_ready = 1'b1;
      @(negedge clk);
      // Seventh byte replaced the sixth waiting in the pending slot
      for (int i = 0; i < 5; i++) get(8'h10 + i[7:0], 1'b1);
      get(8'h16, 1'b1);
      `CHK("out_valid", 1'b0, out_valid)
      @(posedge clk) #1;
      ov_clr = 1'b1;
      @(posedge clk) #1;
      ov_clr = 1'b0;
      @(negedge clk);
      `CHK("overrun", 1'b0, overrun)
      $display("fill test done");
   endtask
   task automatic t_write(input logic e, input logic c, input logic [7:0] b);
      fork
         host.acc(e, 1'b0, 1'b0, c, b);
         get(b, c);
      join
      $display("write test %0h done", b);
   endtask
   task automatic t_spi(input logic c, input logic [7:0] b);
      fork
         host.spi(c, b);
         get(b, c);
      join
      $display("spi test %0h done", b);
   endtask
   // Sink held off so a wrongly taken byte would still be showing
   task automatic t_desel;
      out_ready = 1'b0;
      host.acc(1'b0, 1'b0, 1'b1, 1'b1, 8'h77);
      repeat (8) @(negedge clk);
      `CHK("out_valid", 1'b0, out_valid)
      $display("deselect test done");
   endtask
   task automatic t_i2c;
      int k;
      @(posedge clk) #1;
      out_ready = 1'b0;
      host.i2c(1'b1, {`DHIC_I2C_ADDR_HI, 2'h2}, 8'h40, 8'h5C, k);
      `CHK("i2c_acks", 3, k)
      get(8'h5C, 1'b1);
      @(posedge clk) #1;
      out_ready = 1'b1;
      @(posedge clk) #1;
      out_ready = 1'b0;
      host.i2c(1'b0, {`DHIC_I2C_ADDR_HI, 2'h2}, 8'h40, 8'h5C, k);
      `CHK("i2c_acks", 0, k)
      `CHK("out_valid", 1'b0, out_valid)
      out_ready = 1'b1;
      $display("i2c test done");
   endtask
   initial begin
      bad_count = 0;
      samples_checked = 0;
      rst_b = 1'b0;
      pil = 1'b1;
      ov_clr = 1'b0;
      out_ready = 1'b1;
      strap = 3'h4;
      rd_byte = 8'h00;
      ce = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      rst_b = 1'b1;
      init(3'h4, DHIC_PAR_SEP);
      t_write(1'b0, 1'b1, 8'hA5);
      t_write(1'b0, 1'b0, 8'h3C);
      rd(1'b0, 1'b1);
      t_desel;
      t_fill;
      init(3'h6, DHIC_PAR_E);
      t_write(1'b1, 1'b1, 8'h5A);
      t_write(1'b1, 1'b0, 8'hC6);
      rd(1'b1, 1'b0);
      init(3'h0, DHIC_SPI);
      t_spi(1'b0, 8'hC3);
      t_spi(1'b1, 8'h81);
      init(3'h2, DHIC_I2C);
      t_i2c;
      give_verdict;
   end
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      $display("watchdog expired");
      give_verdict;
   end
endmodule
bind dhic_top dhic_chk u_chk (.clk, .rst_b, .power_init_low, .device_select_b,
   .en_rd_strobe, .rw_wr_strobe, .overrun_clr, .out_ready, .mode, .init_busy,
   .read_pulse, .host_data_bus_oe_b, .out_valid, .out_byte, .out_is_data, .overrun);
`default_nettype wire
